//--- core_ops.sv
// execution logic for fill-ones, sleep and borrow-subtract, with an axi4-lite register port
// Function
// - sleep clears sleep-entry flag and sets watchdog-expiry flag.
// - sleep resets watchdog counter to 00h and its postscaler.
// - sleep enters halted state in phase four after idle second phase.
// - watchdog wake-up clears the watchdog-expiry flag.
// - opcode 0101 01da computes accumulator minus file minus inverted carry.
// - borrow-subtract updates negative, wrap, carry, half-carry and zero flags.
// - bank bit 1 uses bank pointer; bank bit 0 uses access bank.
// - bank bit 0, extended set on, operand up to 5Fh is indexed.
`timescale 1ns/100ps
`default_nettype none
`include "core_ops_consts.svh"
module core_ops
  import core_ops_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [5:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [5:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_rd_en,
  input  wire logic [7:0]        mem_rdata,
  output logic                   mem_wr_en,
  output logic [7:0]             mem_wdata,
  output logic                   watchdog_clear,
  output logic                   sleeping,
  input  wire logic              wake_request,
  input  wire logic              wake_by_watchdog
);
  import core_ops_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [15:0]          opcode, next_opcode;
  logic [7:0]           accum, next_accum;
  logic [`ST_WIDTH-1:0] status, next_status;
  logic [3:0]           bank_pointer, next_bank_pointer;
  logic                 extended, next_extended;
  logic [ADDR_W-1:0]    index_base, next_index_base;
  logic                 busy, next_busy;
  logic                 next_sleeping;
  logic [ADDR_W-1:0]    next_mem_addr;
  logic                 next_mem_rd_en, next_mem_wr_en, next_watchdog_clear;
  logic [7:0]           next_mem_wdata;
  logic                 aw_held, next_aw_held, w_held, next_w_held;
  logic [5:0]           aw_addr, next_aw_addr;
  logic [31:0]          w_data, next_w_data;
  logic [3:0]           w_strb, next_w_strb;
  logic                 next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]           next_bresp, next_rresp;
  logic [31:0]          next_rdata;
  phase_t               phase;
  op_t                  op;

  phase_sequencer u_phase
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (busy),
    .phase   (phase)
  );

  // ****************************************
  // decode and arithmetic
  // ****************************************
  logic [7:0]        operand;
  logic              bank_bit, dest_bit, borrow_in;
  logic [8:0]        diff;
  logic [4:0]        low_diff;
  logic [ADDR_W-1:0] file_addr;

  always_comb
  begin
    operand  = opcode[7:0];
    bank_bit = opcode[8];
    dest_bit = opcode[9];
    if (opcode == `SLEEP_CODE)
      op = OP_SLEEP;
    else if (opcode[15:9] == `FILL_PREFIX)
      op = OP_FILL;
    else if (opcode[15:10] == `SUBB_PREFIX)
      op = OP_SUBB;
    else
      op = OP_NONE;
    if (bank_bit)
      file_addr = {bank_pointer, operand};
    else if (extended && operand <= `INDEXED_LIMIT)
      file_addr = ADDR_W'(index_base + {4'h0, operand});
    else if (operand < `ACCESS_SPLIT)
      file_addr = {4'h0, operand};
    else
      file_addr = {4'hF, operand};
    borrow_in = ~status[`ST_CARRY];
    diff      = {1'b0, accum} - {1'b0, mem_rdata} - {8'h00, borrow_in};
    low_diff  = {1'b0, accum[3:0]} - {1'b0, mem_rdata[3:0]} - {4'h0, borrow_in};
  end

  // ****************************************
  // execution
  // ****************************************
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    next_opcode         = opcode;
    next_accum          = accum;
    next_status         = status;
    next_bank_pointer   = bank_pointer;
    next_extended       = extended;
    next_index_base     = index_base;
    next_busy           = busy;
    next_sleeping       = sleeping;
    next_mem_addr       = mem_addr;
    next_mem_rd_en      = 1'b0;
    next_mem_wr_en      = 1'b0;
    next_mem_wdata      = mem_wdata;
    next_watchdog_clear = 1'b0;
    // software writes land first so that the hardware updates below win on the same edge
    if (wr_go && w_strb[0])
    begin
      unique case (aw_addr)
        `OFS_INSTR:
          if (!busy && !sleeping)
          begin
            next_opcode = w_data[15:0];
            next_busy   = 1'b1;
          end
        `OFS_ACCUM:      next_accum = w_data[7:0];
        `OFS_STATUS:     next_status = w_data[`ST_WIDTH-1:0];
        `OFS_BANK:       next_bank_pointer = w_data[3:0];
        `OFS_CTRL:       next_extended = w_data[`CTRL_EXTENDED];
        `OFS_INDEX_BASE: next_index_base[7:0] = w_data[7:0];
        default:         ;
      endcase
    end
    if (wr_go && w_strb[1] && aw_addr == `OFS_INDEX_BASE)
      next_index_base = {w_data[ADDR_W-1:8], next_index_base[7:0]};
    if (busy)
    begin
      unique case (phase)
        PH_DECODE:
        begin
          next_mem_addr  = file_addr;
          next_mem_rd_en = (op == OP_FILL) || (op == OP_SUBB);
        end
        PH_READ: ;
        PH_PROCESS:
        begin
          if (op == OP_FILL)
          begin
            next_mem_wdata = 8'hFF;
            next_mem_wr_en = 1'b1;
          end
          if (op == OP_SUBB)
          begin
            if (dest_bit)
            begin
              next_mem_wdata = diff[7:0];
              next_mem_wr_en = 1'b1;
            end
            else
              next_accum = diff[7:0];
            next_status[`ST_CARRY]      = ~diff[8];
            next_status[`ST_HALF_CARRY] = ~low_diff[4];
            next_status[`ST_ZERO]       = (diff[7:0] == 8'h00);
            next_status[`ST_NEGATIVE]   = diff[7];
            next_status[`ST_WRAP]       = (accum[7] ^ mem_rdata[7]) & (accum[7] ^ diff[7]);
          end
          if (op == OP_SLEEP)
          begin
            next_status[`ST_SLEEP_ENTRY] = 1'b0;
            next_status[`ST_EXPIRY]      = 1'b1;
            next_watchdog_clear          = 1'b1;
          end
        end
        PH_WRITE:
        begin
          next_busy = 1'b0;
          if (op == OP_SLEEP)
            next_sleeping = 1'b1;
        end
      endcase
    end
    else if (sleeping && (wake_request || wake_by_watchdog))
    begin
      next_sleeping = 1'b0;
      if (wake_by_watchdog)
        next_status[`ST_EXPIRY] = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opcode         <= 16'h0000;
      accum          <= 8'h00;
      status         <= `ST_RESET;
      bank_pointer   <= 4'h0;
      extended       <= 1'b0;
      index_base     <= '0;
      busy           <= 1'b0;
      sleeping       <= 1'b0;
      mem_addr       <= '0;
      mem_rd_en      <= 1'b0;
      mem_wr_en      <= 1'b0;
      mem_wdata      <= 8'h00;
      watchdog_clear <= 1'b0;
    end
    else
    begin
      opcode         <= next_opcode;
      accum          <= next_accum;
      status         <= next_status;
      bank_pointer   <= next_bank_pointer;
      extended       <= next_extended;
      index_base     <= next_index_base;
      busy           <= next_busy;
      sleeping       <= next_sleeping;
      mem_addr       <= next_mem_addr;
      mem_rd_en      <= next_mem_rd_en;
      mem_wr_en      <= next_mem_wr_en;
      mem_wdata      <= next_mem_wdata;
      watchdog_clear <= next_watchdog_clear;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic addr_known_w, addr_known_r;

  always_comb
  begin
    addr_known_w = (aw_addr <= `OFS_INDEX_BASE) && (aw_addr[1:0] == 2'h0);
    addr_known_r = (s_axi_araddr <= `OFS_INDEX_BASE) && (s_axi_araddr[1:0] == 2'h0);
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = addr_known_w ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = addr_known_r ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_INSTR:      next_rdata = {16'h0000, opcode};
        `OFS_ACCUM:      next_rdata = {24'h000000, accum};
        `OFS_STATUS:     next_rdata = {25'h0000000, status};
        `OFS_BANK:       next_rdata = {28'h0000000, bank_pointer};
        `OFS_CTRL:       next_rdata = {22'h000000, sleeping, busy, 7'h00, extended};
        `OFS_INDEX_BASE: next_rdata = {{(32-ADDR_W){1'b0}}, index_base};
        default:         next_rdata = 32'h00000000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 6'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end
endmodule
`default_nettype wire

//--- core_ops_consts.svh
// constants for the sleep, fill-ones and borrow-subtract execution block
`ifndef CORE_OPS_CONSTS_SVH
`define CORE_OPS_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_INSTR        6'h00
`define OFS_ACCUM        6'h04
`define OFS_STATUS       6'h08
`define OFS_BANK         6'h0C
`define OFS_CTRL         6'h10
`define OFS_INDEX_BASE   6'h14

// ****************************************
// status field positions
// ****************************************
`define ST_CARRY         0
`define ST_HALF_CARRY    1
`define ST_ZERO          2
`define ST_WRAP          3
`define ST_NEGATIVE      4
`define ST_EXPIRY        5
`define ST_SLEEP_ENTRY   6
`define ST_WIDTH         7
`define ST_RESET         7'h60

// ****************************************
// control field positions
// ****************************************
`define CTRL_EXTENDED    0
`define CTRL_BUSY        8
`define CTRL_SLEEPING    9

// ****************************************
// opcode patterns
// ****************************************
`define SLEEP_CODE       16'h0003
`define FILL_PREFIX      7'h34
`define SUBB_PREFIX      6'h15
`define INDEXED_LIMIT    8'h5F
`define ACCESS_SPLIT     8'h60
`define WATCHDOG_CLEARED 8'h00
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- core_ops_pkg.sv
// types shared by the execution block
package core_ops_pkg;
  typedef enum logic [1:0]
  {
    OP_NONE  = 2'b00,
    OP_FILL  = 2'b01,
    OP_SUBB  = 2'b10,
    OP_SLEEP = 2'b11
  } op_t;

  typedef enum logic [1:0]
  {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_t;
endpackage

//--- phase_sequencer.sv
// four-phase instruction cycle counter
`timescale 1ns/100ps
`default_nettype none
module phase_sequencer
  import core_ops_pkg::*;
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            run,
  output core_ops_pkg::phase_t phase
);
  phase_t next_phase;

  always_comb
  begin
    next_phase = run ? phase_t'(phase + 2'h1) : PH_DECODE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase <= PH_DECODE;
    else
      phase <= next_phase;
  end
endmodule
`default_nettype wire

//--- core_ops_properties.sv
// port assertions for the execution block
`timescale 1ns/100ps
`default_nettype none
module core_ops_properties
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic watchdog_clear,
  input wire logic sleeping,
  input wire logic wake_request,
  input wire logic wake_by_watchdog
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************
  // instruction phases
  // ****************************************
  // read slot, idle process slot, then the write slot with no second read;
  // a subtract into the accumulator leaves the write slot empty
  sequence read_then_write;
    mem_rd_en ##1 (!mem_rd_en && !mem_wr_en) ##1 (!mem_rd_en && !watchdog_clear);
  endsequence
  sequence clear_then_halt;
    (watchdog_clear && !mem_wr_en) ##1 sleeping;
  endsequence

  a_read_write_pair: assert property (mem_rd_en |-> read_then_write)
    else $error("write slot did not follow the read slot");
  a_write_has_read: assert property (mem_wr_en |-> $past(mem_rd_en, 2))
    else $error("write slot without a read two cycles before");
  a_sleep_entry_order: assert property (watchdog_clear |-> clear_then_halt)
    else $error("halt did not follow the watchdog clear");
  a_sleep_no_read: assert property (watchdog_clear |-> !$past(mem_rd_en) && !$past(mem_rd_en, 2))
    else $error("sleep instruction read the file operand");
  a_clear_single_pulse: assert property (watchdog_clear |=> !watchdog_clear [*3])
    else $error("watchdog clear longer than one cycle");
  a_halt_has_clear: assert property ($rose(sleeping) |-> $past(watchdog_clear))
    else $error("halt entered without clearing the watchdog");
  a_halted_quiet: assert property (sleeping |-> !mem_rd_en && !mem_wr_en && !watchdog_clear)
    else $error("memory or watchdog activity while halted");
  a_wake_exit: assert property (sleeping && (wake_request || wake_by_watchdog) |-> ##[1:2] !sleeping)
    else $error("wake input did not end the halt");
  a_halt_holds: assert property (sleeping && !wake_request && !wake_by_watchdog && !$past(wake_request)
    && !$past(wake_by_watchdog) |=> sleeping)
    else $error("halt ended with no wake input");
endmodule

bind core_ops core_ops_properties core_ops_properties_inst
  (.aclk, .aresetn, .mem_rd_en, .mem_wr_en, .watchdog_clear, .sleeping, .wake_request, .wake_by_watchdog);
`default_nettype wire

//--- data_mem_model.sv
// behavioural data memory on the far side of the file-operand port
`timescale 1ns/100ps
`default_nettype none
module data_mem_model
(
  input  wire logic        aclk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd_en,
  output logic      [7:0]  mem_rdata,
  input  wire logic        mem_wr_en,
  input  wire logic [7:0]  mem_wdata
);
  logic [7:0] mem [4096];

  initial mem_rdata = 8'h00;
  // outside the read slot the bus toggles, so stale data never passes for a good read
  always @(posedge aclk)
  begin
    if (mem_rd_en)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr_en)
      mem[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

//--- sleep_and_borrow_subtract_ops_bench.sv
// self-checking bench: fill, borrow-subtract and sleep through the register port
`timescale 1ns/100ps
`default_nettype none
`include "core_ops_consts.svh"
module sleep_and_borrow_subtract_ops_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        mem_rd_en, mem_wr_en, watchdog_clear, sleeping, wake_request, wake_by_watchdog;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rdata, mem_wdata;
  int          errors, tests_run, clears, reads;
  logic [15:0] fop [5] = '{16'h693C, 16'h6820, 16'h6890, 16'h685F, 16'h6860};
  logic [11:0] fad [5] = '{12'h53C, 12'h020, 12'hF90, 12'h25F, 12'hF60};

  core_ops core_ops_inst
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata, .watchdog_clear, .sleeping,
    .wake_request, .wake_by_watchdog
  );
  data_mem_model data_mem_model_inst
  (
    .aclk, .mem_addr, .mem_rd_en, .mem_rdata, .mem_wr_en, .mem_wdata
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    if (watchdog_clear === 1'b1)
      clears++;
    if (mem_rd_en === 1'b1)
      reads++;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 60)
    begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up();
    end
  endtask
  // one transfer; request held until its own ready edge, answer taken at the valid edge
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    if (wr)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 60);
    bound(n);
    r = wr ? s_axi_bresp : s_axi_rresp;
    q = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic run(input logic [15:0] op);
    int n;
    n = 0;
    bus(1, `OFS_INSTR, {16'h0000, op});
    do
    begin
      bus(0, `OFS_CTRL, 32'h0);
      n++;
    end
    while (q[`CTRL_BUSY] !== 1'b0 && n < 60);
    bound(n);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int w, x, c, d, b, f, ad, res, rb, h, fl;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, wake_request, wake_by_watchdog} = '0;
    s_axi_wstrb = 4'hF;
    {errors, tests_run, clears, reads} = '0;
    void'($urandom(32'hF1F9));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, `OFS_STATUS, 32'h0);
    chk(q, {25'h0, `ST_RESET});
    bus(0, 6'h18, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    chk(q, 32'h0);
    bus(1, 6'h18, 32'hFF);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    $display("test reset and refusals done");
    bus(1, `OFS_BANK, 32'h5);
    bus(1, `OFS_INDEX_BASE, 32'h200);
    for (int k = 0; k < 5; k++)
    begin
      data_mem_model_inst.mem[fad[k]] = 8'h5A;
      bus(1, `OFS_CTRL, {31'h0, k > 2});
      bus(0, `OFS_STATUS, 32'h0);
      w = q;
      run(fop[k]);
      chk(data_mem_model_inst.mem[fad[k]], 32'hFF);
      bus(0, `OFS_STATUS, 32'h0);
      chk(q, w);
    end
    $display("test fill across address modes done");
    bus(1, `OFS_CTRL, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      w = $urandom % 256;
      x = (i == 0) ? w : $urandom % 256;
      c = (i == 0) ? 1 : $urandom % 2;
      d = $urandom % 2;
      b = $urandom % 16;
      f = $urandom % 256;
      ad = b * 256 + f;
      data_mem_model_inst.mem[ad] = x[7:0];
      bus(1, `OFS_BANK, b);
      bus(1, `OFS_ACCUM, w);
      bus(1, `OFS_STATUS, 32'h60 + c);
      run(16'(32'h5500 + d * 512 + f));
      res = w - x - (1 - c);
      rb = res & 255;
      h = (w & 15) - (x & 15) - (1 - c);
      fl = int'(res >= 0) + 2 * int'(h >= 0) + 4 * int'(rb == 0) + 16 * (rb / 128);
      fl += 8 * int'(((w ^ x) & (w ^ rb) & 128) != 0);
      bus(0, `OFS_STATUS, 32'h0);
      chk({27'h0, q[4:0]}, fl);
      bus(0, `OFS_ACCUM, 32'h0);
      chk({24'h0, q[7:0]}, d ? w : rb);
      chk(data_mem_model_inst.mem[ad], d ? rb : x);
    end
    $display("test borrow-subtract done");
    clears = 0;
    reads = 0;
    run(`SLEEP_CODE);
    bus(0, `OFS_CTRL, 32'h0);
    chk(q[`CTRL_SLEEPING], 1);
    chk(sleeping, 1);
    bus(0, `OFS_STATUS, 32'h0);
    chk(q[6:5], 2'b01);
    chk(clears, 1);
    chk(reads, 0);
    data_mem_model_inst.mem[12'h020] = 8'h11;
    // the block ignores opcodes while halted; give one full instruction span and more
    bus(1, `OFS_INSTR, 32'h6820);
    repeat (6) @(posedge aclk);
    chk(data_mem_model_inst.mem[12'h020], 32'h11);
    wake_by_watchdog <= 1'b1;
    @(posedge aclk);
    wake_by_watchdog <= 1'b0;
    bus(0, `OFS_CTRL, 32'h0);
    chk(q[`CTRL_SLEEPING], 0);
    chk(sleeping, 0);
    bus(0, `OFS_STATUS, 32'h0);
    chk(q[5], 0);
    run(`SLEEP_CODE);
    wake_request <= 1'b1;
    @(posedge aclk);
    wake_request <= 1'b0;
    bus(0, `OFS_STATUS, 32'h0);
    chk(q[6:5], 2'b01);
    bus(0, `OFS_CTRL, 32'h0);
    chk(q[`CTRL_SLEEPING], 0);
    chk(clears, 2);
    $display("test sleep and wake done");
    wrap_up();
  end
endmodule
`default_nettype wire
